//--- hw/gpio_pwm_cfg.svh
// register indices, field positions, reset values and tick counts
`ifndef GPIO_PWM_CFG_SVH
`define GPIO_PWM_CFG_SVH
`define IDX_STATUS 8'h4c
`define IDX_CFG 8'h4d
`define IDX_DATA 8'h4e
`define IDX_LL 8'h4f
`define IDX_LH 8'h50
`define RST_CFG 16'h0000
`define RST_DATA 16'h0000
`define RST_LL 16'h007f
`define RST_LH 16'h3f80
`define MASK_CFG 16'h7ffd
`define MASK_LH 16'h3fff
`define DIR_LSB 5
`define FMT0_BIT 10
`define TICKS_TB0 10'h00f
`define TICKS_TB1 10'h03f
`define TICKS_TB2 10'h0ff
`define TICKS_TB3 10'h3ff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hw/gpio_pwm_pkg.sv
// types shared by the pin block
package gpio_pwm_pkg;
  typedef enum logic {PH_HIGH, PH_LOW} pwm_phase_e;
  typedef logic [15:0] reg16_t;
  typedef logic [1:0] axi_resp_t;
endpackage

//--- hw/gpio_output_pwm_encoder.sv
// pin direction, source select, output data and pin 0 pwm encoder
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "gpio_pwm_cfg.svh"
//
// Behaviour
// RULE_01 - config bits 9..5 set pin 4..0 direction, 1 means output.
// RULE_02 - pin 4 output: select 0 drives comparator B, 1 drives data.
// RULE_03 - pin 3 output: select 0 drives comparator A, 1 drives data.
// RULE_04 - pin 2 output: select 0 drives fault, 1 drives data.
// RULE_05 - pin 0 output: select 0 drives missing-host detect, 1 data.
// RULE_06 - config bit 1 ignores writes and reads zero.
// RULE_07 - pin 1 output always drives its data bit.
// RULE_08 - software sets output direction for internal function pins.
// RULE_09 - data bits 15..5 are plain storage with no pin effect.
// RULE_10 - data bits 4..0 set output pin level, 1 high.
// RULE_11 - data bit ignored for input pins or function-routed pins.
// RULE_12 - time base code selects 16, 64, 256 or 1024 clocks.
// RULE_13 - encoded level drives high for high count times time base.
// RULE_14 - encoded level drives low for low count times time base.
// RULE_15 - zero high count gives static low.
// RULE_16 - zero low count, nonzero high count gives static high.
// RULE_17 - both counts zero gives static low.
// RULE_18 - low-level pwm register resets to 007f.
// RULE_19 - high then low phase repeat, counts reload each period.
// RULE_20 - pin 0 format bit selects static or pwm encoded output.
// RULE_21 - logic high uses its own register with same rules; code takes time base from the low-level register.
module gpio_output_pwm_encoder #(
  parameter int ADDR_W = 12
) (
  input logic mclk,
  input logic sys_rst,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output gpio_pwm_pkg::axi_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output gpio_pwm_pkg::axi_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic overcurrentCompareAOut,
  input logic overcurrentCompareBOut,
  input logic faultIndication,
  input logic missingHostDetectOut,
  input logic [4:0] pinIn,
  output logic [4:0] pinOut,
  output logic [4:0] pinOutEn
);
  import gpio_pwm_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // word index of a byte address, with a flag for address bits above it
  function automatic logic [8:0] wordIdx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] hi;
    hi = a >> 10;
    wordIdx = {hi != '0, a[9:2]};
  endfunction

  // byte-lane merge of a write into a 16-bit register
  function automatic reg16_t merge(input reg16_t old,
    input logic [31:0] d, input logic [3:0] s, input reg16_t m);
    reg16_t v;
    v = old;
    if (s[0]) v[7:0] = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    merge = v & m;
  endfunction

  // last count of the time-base divider
  function automatic logic [9:0] tickLast(input logic [1:0] tb);
    unique case (tb)
      2'h0: tickLast = `TICKS_TB0;
      2'h1: tickLast = `TICKS_TB1;
      2'h2: tickLast = `TICKS_TB2;
      2'h3: tickLast = `TICKS_TB3;
    endcase
  endfunction

  // ****************************************
  // register bus and register file
  // ****************************************
  reg16_t pinFunctionConfig, pinOutputValues;
  reg16_t pin0LowLevelPwmConfig, pin0HighLevelPwmConfig;
  reg16_t next_cfg, next_data, next_ll, next_lh;
  logic awHave, wHave, next_awHave, next_wHave;
  logic [8:0] awIdx, next_awIdx, rIdx, next_rIdx;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic next_bvalid, next_rvalid;
  axi_resp_t next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic pwmLevel;

  // aw and w may arrive in either order; the write lands when both held
  always_comb
  begin
    next_cfg = pinFunctionConfig;
    next_data = pinOutputValues;
    next_ll = pin0LowLevelPwmConfig;
    next_lh = pin0HighLevelPwmConfig;
    next_awHave = awHave;
    next_wHave = wHave;
    next_awIdx = awIdx;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rIdx = rIdx;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHave = 1'b1;
      next_awIdx = wordIdx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHave = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (awHave && wHave && !s_axi_bvalid)
    begin
      next_awHave = 1'b0;
      next_wHave = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      unique case (awIdx)
        {1'b0, `IDX_CFG}: // reserved bits 15 and 1 masked off [RULE_06]
          next_cfg = merge(pinFunctionConfig, wData, wStrb, `MASK_CFG);
        {1'b0, `IDX_DATA}: // spare upper bits simply stored [RULE_09]
          next_data = merge(pinOutputValues, wData, wStrb, 16'hffff);
        {1'b0, `IDX_LL}:
          next_ll = merge(pin0LowLevelPwmConfig, wData, wStrb, 16'hffff);
        {1'b0, `IDX_LH}:
          next_lh = merge(pin0HighLevelPwmConfig, wData, wStrb, `MASK_LH);
        {1'b0, `IDX_STATUS}: ; // read-only, write dropped
        default: next_bresp = `RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rIdx = wordIdx(s_axi_araddr);
      next_rresp = `RESP_OKAY;
      unique case (wordIdx(s_axi_araddr))
        {1'b0, `IDX_STATUS}: next_rdata = {26'h0, pwmLevel, pinIn};
        {1'b0, `IDX_CFG}: next_rdata = {16'h0, pinFunctionConfig};
        {1'b0, `IDX_DATA}: next_rdata = {16'h0, pinOutputValues};
        {1'b0, `IDX_LL}: next_rdata = {16'h0, pin0LowLevelPwmConfig};
        {1'b0, `IDX_LH}: next_rdata = {16'h0, pin0HighLevelPwmConfig};
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  // readies come from flops, so a held address is never overwritten
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pinFunctionConfig <= `RST_CFG;
      pinOutputValues <= `RST_DATA;
      pin0LowLevelPwmConfig <= `RST_LL; // [RULE_18]
      pin0HighLevelPwmConfig <= `RST_LH;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awIdx <= 9'h0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      rIdx <= 9'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      pinFunctionConfig <= next_cfg;
      pinOutputValues <= next_data;
      pin0LowLevelPwmConfig <= next_ll;
      pin0HighLevelPwmConfig <= next_lh;
      awHave <= next_awHave;
      wHave <= next_wHave;
      awIdx <= next_awIdx;
      wData <= next_wData;
      wStrb <= next_wStrb;
      rIdx <= next_rIdx;
      s_axi_awready <= !next_awHave;
      s_axi_wready <= !next_wHave;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************
  // pin 0 pwm encoder
  // ****************************************
  logic [4:0] dir, src, dat;
  logic level0, pwmActive, waveOn, tick;
  reg16_t selCfg;
  logic [6:0] selHc, selLc, curHc, curLc, next_curHc, next_curLc;
  logic [6:0] phaseCnt, next_phaseCnt;
  logic [9:0] tickCnt, next_tickCnt;
  pwm_phase_e phase, next_phase;

  assign dir = pinFunctionConfig[`DIR_LSB+4:`DIR_LSB];
  assign src = {pinFunctionConfig[4:2], 1'b1, pinFunctionConfig[0]};
  assign dat = pinOutputValues[4:0];
  assign level0 = src[0] ? dat[0] : missingHostDetectOut;
  assign selCfg = level0 ? pin0HighLevelPwmConfig
                         : pin0LowLevelPwmConfig; // [RULE_21]
  assign selHc = selCfg[13:7];
  assign selLc = selCfg[6:0];
  assign pwmActive = dir[0] && pinFunctionConfig[`FMT0_BIT]; // [RULE_20]
  assign waveOn = pwmActive && selHc != 7'h0 && selLc != 7'h0;
  // >= so that shrinking the time base mid-count cannot skip a tick
  assign tick = tickCnt >= tickLast(pin0LowLevelPwmConfig[15:14]);
  // zero high count gives low, zero low count alone gives high
  assign pwmLevel = waveOn ? (phase == PH_HIGH)
                           : (selHc != 7'h0); // [RULE_15] [RULE_16] [RULE_17]

  // the generator restarts from a fresh high phase when leaving static
  always_comb
  begin
    next_tickCnt = tick ? 10'h0 : tickCnt + 10'h1; // [RULE_12]
    next_phase = phase;
    next_phaseCnt = phaseCnt;
    next_curHc = curHc;
    next_curLc = curLc;
    if (!waveOn)
    begin
      next_tickCnt = 10'h0;
      next_phase = PH_HIGH;
      next_phaseCnt = 7'h0;
      next_curHc = selHc;
      next_curLc = selLc;
    end
    else if (tick)
    begin
      next_phaseCnt = phaseCnt + 7'h1;
      unique case (phase)
        PH_HIGH:
          if (phaseCnt == curHc - 7'h1) // [RULE_13]
          begin
            next_phase = PH_LOW;
            next_phaseCnt = 7'h0;
          end
        PH_LOW:
          if (phaseCnt == curLc - 7'h1) // [RULE_14]
          begin
            next_phase = PH_HIGH; // new period, counts reloaded [RULE_19]
            next_phaseCnt = 7'h0;
            next_curHc = selHc;
            next_curLc = selLc;
          end
      endcase
    end
    // first clock of a period takes the counts standing now, so a waveform
    // that starts right after a write never runs on counts latched before it
    if (waveOn && phase == PH_HIGH && phaseCnt == 7'h0 && tickCnt == 10'h0)
    begin
      next_curHc = selHc; // [RULE_19]
      next_curLc = selLc;
    end
  end

  // encoder state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tickCnt <= 10'h0;
      phase <= PH_HIGH;
      phaseCnt <= 7'h0;
      curHc <= 7'h0;
      curLc <= 7'h0;
    end
    else
    begin
      tickCnt <= next_tickCnt;
      phase <= next_phase;
      phaseCnt <= next_phaseCnt;
      curHc <= next_curHc;
      curLc <= next_curLc;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic [4:0] next_pinOut;

  // source select per pin; input pins drive nothing [RULE_11]
  always_comb
  begin
    next_pinOut[4] = src[4] ? dat[4] : overcurrentCompareBOut; // [RULE_02]
    next_pinOut[3] = src[3] ? dat[3] : overcurrentCompareAOut; // [RULE_03]
    next_pinOut[2] = src[2] ? dat[2] : faultIndication; // [RULE_04]
    next_pinOut[1] = dat[1]; // [RULE_07] [RULE_10]
    next_pinOut[0] = pwmActive ? pwmLevel : level0; // [RULE_05]
    next_pinOut = next_pinOut & dir;
  end

  // pins registered straight onto the ports
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pinOut <= 5'h0;
      pinOutEn <= 5'h0;
    end
    else
    begin
      pinOut <= next_pinOut;
      pinOutEn <= dir; // [RULE_01]
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence highEnds;
    waveOn && tick && phase == PH_HIGH && phaseCnt == curHc - 7'h1;
  endsequence
  sequence lowStarts;
    phase == PH_LOW && phaseCnt == 7'h0;
  endsequence

  dir_enable_a: assert property (##1 pinOutEn == $past(dir)) // [RULE_01]
    else $error("pin enable does not follow direction");
  pin4_source_a: assert property (dir[4] && !src[4] |=> // [RULE_02]
    pinOut[4] == $past(overcurrentCompareBOut))
    else $error("pin 4 not carrying comparator b");
  pin3_source_a: assert property (dir[3] && !src[3] |=> // [RULE_03]
    pinOut[3] == $past(overcurrentCompareAOut))
    else $error("pin 3 not carrying comparator a");
  pin2_source_a: assert property (dir[2] && !src[2] |=> // [RULE_04]
    pinOut[2] == $past(faultIndication))
    else $error("pin 2 not carrying fault");
  pin0_source_a: assert property (dir[0] && !src[0] // [RULE_05]
    && !pwmActive |=> pinOut[0] == $past(missingHostDetectOut))
    else $error("pin 0 not carrying host detect");
  cfg_reserved_a: assert property (s_axi_rvalid && // [RULE_06]
    rIdx == {1'b0, `IDX_CFG} |-> !s_axi_rdata[1] && !s_axi_rdata[15])
    else $error("reserved config bits read nonzero");
  pin1_data_a: assert property (dir[1] |=> // [RULE_07]
    pinOut[1] == $past(dat[1]))
    else $error("pin 1 not driving its data bit");
  input_quiet_a: assert property (##1 // [RULE_11]
    (pinOut & ~$past(dir)) == 5'h0)
    else $error("input pin driven high");
  static_low_a: assert property (pwmActive && selHc == 7'h0 |=> // [RULE_15]
    !pinOut[0])
    else $error("zero high count not static low");
  static_high_a: assert property (pwmActive && selHc != 7'h0 && // [RULE_16]
    selLc == 7'h0 |=> pinOut[0])
    else $error("zero low count not static high");
  high_phase_a: assert property (waveOn && phase == PH_HIGH |=> // [RULE_13]
    pinOut[0])
    else $error("pwm high phase not driving high");
  low_phase_a: assert property (waveOn && phase == PH_LOW |=> // [RULE_14]
    !pinOut[0])
    else $error("pwm low phase not driving low");
  phase_turn_a: assert property (highEnds |=> lowStarts) // [RULE_19]
    else $error("high phase did not hand over to low");
  tick_wrap_a: assert property (waveOn && tick |=> // [RULE_12]
    tickCnt == 10'h0)
    else $error("time base divider did not wrap");
  ll_reset_a: assert property ($past(sys_rst) |-> // [RULE_18]
    pin0LowLevelPwmConfig == `RST_LL)
    else $error("low-level pwm reset value wrong");
endmodule

//--- tb/pin_host_model.sv
// host-side model that drives released pins and times pin 0 runs
`timescale 1ns/1ns
// ********************************************************
// host observer
// ********************************************************
module pin_host_model (
  input wire logic mclk,
  input wire logic [4:0] pinOut,
  input wire logic [4:0] pinOutEn,
  input wire logic [4:0] hostDrive,
  output logic [4:0] pinIn,
  output int hiLen,
  output int loLen
);
  int run = 0;
  logic last = 1'b0;
  // block wins wherever it drives; the host owns every released pin
  assign pinIn = (pinOutEn & pinOut) | (~pinOutEn & hostDrive);
  // run length in clocks, stored when the level turns over
  always @(posedge mclk)
  begin
    if (pinIn[0] !== last)
    begin
      if (last) hiLen <= run;
      else loLen <= run;
      run <= 1;
    end
    else run <= run + 1;
    last <= pinIn[0];
  end
endmodule

//--- tb/gpio_output_pwm_encoder_tb.sv
// self-checking bench for the pin block and its pin 0 encoder
`timescale 1ns/1ns
`include "gpio_pwm_cfg.svh"
module gpio_output_pwm_encoder_tb;
  import gpio_pwm_pkg::*;
  localparam logic [11:0] aStat = {2'b00, `IDX_STATUS, 2'b00};
  localparam logic [11:0] aCfg = {2'b00, `IDX_CFG, 2'b00};
  localparam logic [11:0] aDat = {2'b00, `IDX_DATA, 2'b00};
  localparam logic [11:0] aLl = {2'b00, `IDX_LL, 2'b00};
  localparam logic [11:0] aLh = {2'b00, `IDX_LH, 2'b00};
  localparam logic [11:0] aBad = 12'h100;
  logic mclk, sysRst, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, cmpA, cmpB, fault, hostLost;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  axi_resp_t bResp, rResp;
  logic [4:0] pinIn, pinOut, pinOutEn, hostDrive;
  int hiLen, loLen;
  int numErrors = 0;
  int nTests = 0;
  gpio_output_pwm_encoder gpio_output_pwm_encoder_inst (.mclk(mclk),
    .sys_rst(sysRst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .overcurrentCompareAOut(cmpA), .overcurrentCompareBOut(cmpB),
    .faultIndication(fault), .missingHostDetectOut(hostLost),
    .pinIn(pinIn), .pinOut(pinOut), .pinOutEn(pinOutEn));
  pin_host_model pin_host_model_inst (.mclk(mclk), .pinOut(pinOut),
    .pinOutEn(pinOutEn), .hostDrive(hostDrive), .pinIn(pinIn),
    .hiLen(hiLen), .loLen(loLen));
  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (numErrors == 0 && nTests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a wait that ran out is a mismatch and ends the run
  task automatic late();
    numErrors++;
    tally_and_finish();
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axWrite(input logic [11:0] a, input logic [31:0] d,
                         input axi_resp_t er);
    int n;
    @(posedge mclk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge mclk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    if (n == 100) late();
    bReady <= 1'b0;
    chk(32'(bResp), 32'(er));
  endtask
  task automatic axRead(input logic [11:0] a, input axi_resp_t er,
                        output logic [31:0] d);
    int n;
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge mclk);
      if (arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    if (n == 100) late();
    d = rData;
    rReady <= 1'b0;
    chk(32'(rResp), 32'(er));
  endtask
  // pin 0 must sit at one level for the whole stretch
  task automatic holdChk(input logic lvl, input int n);
    logic moved;
    moved = 1'b0;
    repeat (4) @(posedge mclk);
    repeat (n)
    begin
      @(posedge mclk);
      if (pinOut[0] !== lvl) moved = 1'b1;
    end
    chk(32'(moved), 32'h0);
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic resetValues();
    logic [31:0] d;
    axRead(aLl, `RESP_OKAY, d);
    chk(d, 32'h0000007f);
    axRead(aLh, `RESP_OKAY, d);
    chk(d, 32'h00003f80);
    axRead(aDat, `RESP_OKAY, d);
    chk(d, 32'h0);
    axRead(aBad, `RESP_SLVERR, d);
    chk(d, 32'h0);
  endtask
  // reserved bit stays zero, spare bits store but leave pins alone
  task automatic regAccess();
    logic [31:0] d;
    axWrite(aCfg, 32'hffff, `RESP_OKAY);
    axRead(aCfg, `RESP_OKAY, d);
    chk(d, 32'h7ffd);
    axWrite(aDat, 32'hffe0, `RESP_OKAY);
    axRead(aDat, `RESP_OKAY, d);
    chk(d, 32'hffe0);
    chk(32'(pinOut), 32'h0);
    axWrite(aBad, 32'h1234, `RESP_SLVERR);
  endtask
  task automatic pinLevels();
    logic [31:0] d;
    logic [4:0] v;
    axWrite(aCfg, 32'h03fd, `RESP_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 5'h15 : 5'h0a;
      axWrite(aDat, 32'(v), `RESP_OKAY);
      repeat (3) @(posedge mclk);
      chk(32'(pinOut), 32'(v));
      chk(32'(pinOutEn), 32'h1f);
    end
    axWrite(aCfg, 32'h001d, `RESP_OKAY);
    hostDrive <= 5'h15;
    repeat (3) @(posedge mclk);
    chk(32'(pinOutEn), 32'h0);
    chk(32'(pinOut), 32'h0);
    axRead(aStat, `RESP_OKAY, d);
    chk(32'(d[4:0]), 32'h15);
  endtask
  task automatic functionRoutes();
    logic [4:0] e;
    axWrite(aCfg, 32'h03e0, `RESP_OKAY);
    axWrite(aDat, 32'h001f, `RESP_OKAY);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      {cmpB, cmpA, fault, hostLost} <= 4'(i);
      repeat (4) @(posedge mclk);
      e = {i[3], i[2], i[1], 1'b1, i[0]};
      chk(32'(pinOut), 32'(e));
    end
    axWrite(aDat, 32'h0, `RESP_OKAY);
    repeat (3) @(posedge mclk);
    chk(32'(pinOut), 32'h1d);
  endtask
  task automatic pwmLevels();
    int tb;
    axWrite(aCfg, 32'h0421, `RESP_OKAY);
    axWrite(aLl, 32'h0005, `RESP_OKAY);
    holdChk(1'b0, 100);
    axWrite(aLl, 32'h0280, `RESP_OKAY);
    holdChk(1'b1, 100);
    axWrite(aLl, 32'h0, `RESP_OKAY);
    holdChk(1'b0, 100);
    axWrite(aDat, 32'h1, `RESP_OKAY);
    holdChk(1'b1, 100);
    axWrite(aDat, 32'h0, `RESP_OKAY);
    // high count 2, low count 1 under every time base code
    for (int c = 0; c < 4; c++)
    begin
      tb = 16 << (2 * c);
      axWrite(aLl, 32'(c << 14) | 32'h0101, `RESP_OKAY);
      repeat (12 * tb + 50) @(posedge mclk);
      chk(32'(hiLen), 32'(2 * tb));
      chk(32'(loLen), 32'(tb));
    end
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    sysRst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    {cmpA, cmpB, fault, hostLost} = 4'h0;
    awAddr = 12'h000;
    arAddr = 12'h000;
    wData = 32'h0;
    wStrb = 4'hf;
    hostDrive = 5'h00;
    repeat (10) @(posedge mclk);
    sysRst <= 1'b0;
    repeat (2) @(posedge mclk);
    resetValues();
    regAccess();
    pinLevels();
    functionRoutes();
    pwmLevels();
    tally_and_finish();
  end
endmodule
